/* core/sfsp_device.sv */
// device end of the serial flash link: pin sampling, framing, page buffer
// assumes link pins are asynchronous to sys_clk and sck is slow enough to be sampled
`default_nettype none

// ----------------------------------------
// small valid/ready fifo
// ----------------------------------------
module sfsp_fifo #(
  parameter int W = 8,
  parameter int D = 4
) (
  // clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rst_n,
  // fill side
  input  wire logic         inValid,
  output logic              inReady,
  input  wire logic [W-1:0] inData,
  // drain side
  output logic              outValid,
  input  wire logic         outReady,
  output logic [W-1:0]      outData
);
  localparam int AW = $clog2(D);
  localparam int CW = $clog2(D + 1);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wp;
    logic [AW-1:0]       rp;
    logic [CW-1:0]       cnt;
  } sfsp_fifo_s;
  sfsp_fifo_s st_ff, nxt_st;

  assign inReady  = (st_ff.cnt != CW'(D));
  assign outValid = (st_ff.cnt != '0);
  assign outData  = st_ff.mem[st_ff.rp];

  always_comb begin
    nxt_st = st_ff;
    if (inValid && inReady) begin
      nxt_st.mem[st_ff.wp] = inData;
      nxt_st.wp = (st_ff.wp == AW'(D - 1)) ? '0 : st_ff.wp + AW'(1);
    end
    if (outValid && outReady) begin
      nxt_st.rp = (st_ff.rp == AW'(D - 1)) ? '0 : st_ff.rp + AW'(1);
    end
    nxt_st.cnt = st_ff.cnt + CW'(inValid && inReady) - CW'(outValid && outReady);
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
endmodule : sfsp_fifo

// Behaviour
// - idle clock level low or high both work
// - host keeps sck at or below 66 MHz
// - select falls to start, rises to end
// - output released while deselected
// - input ignored while deselected
// - deselect enters standby, never deep power-down
// - standby waits for self-timed work
// - input sampled on sck rising edge
// - output changes on sck falling edge
// - host sends everything on one input line
// - page size 256 or 264, factory 256
// - memory holds 512 pages
// - one buffer the length of a page
// - program and erase are self-timed
// - all bytes travel msb first
// - host sends opcode then address
// - reset aborts and holds logic idle
module sfsp_device
  import sfsp_pkg::*;
#(
  parameter bit FACTORY_256 = 1'b0,
  parameter int SELF_TIME   = SELF_CYCLES
) (
  // clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 rst_n,
  // link
  sfsp_link_if.dev                  link,
  // configuration
  input  wire logic                 cfgPageLarge,
  // received bytes
  output logic                      rxValid,
  input  wire logic                 rxReady,
  output logic [BYTE_BITS-1:0]      rxData,
  output logic                      rxOverrun,
  input  wire logic                 clrOverrun,
  // bytes to send
  input  wire logic [BYTE_BITS-1:0] txData,
  output logic                      txTake,
  // page buffer and array address
  input  wire logic [PAGE_AW-1:0]   bufRdAddr,
  output logic [BYTE_BITS-1:0]      bufRdData,
  output logic [PAGE_AW-1:0]        pageAddr,
  // self-timed work and power state
  input  wire logic                 workStart,
  output logic                      busy,
  output logic                      standby,
  output logic                      deepPowerDown
);
  localparam int TW = $clog2(SELF_TIME + 1);
  typedef struct packed {
    logic [SYNC_STAGES-1:0]               csS;
    logic [SYNC_STAGES-1:0]               sckS;
    logic [SYNC_STAGES-1:0]               siS;
    logic                                 csF;
    logic                                 sckF;
    logic                                 siF;
    logic [BYTE_BITS-1:0]                 rxSh;
    logic [2:0]                           bitCnt;
    logic                                 sawRise;
    logic [2:0]                           hdrCnt;
    logic [BYTE_BITS-1:0]                 txSh;
    logic                                 soOut;
    logic                                 soOeN;
    logic                                 txTake;
    logic                                 pend;
    logic [BYTE_BITS-1:0]                 pendData;
    logic                                 overrun;
    logic [PAGE_AW-1:0]                   bufPtr;
    logic [PAGE_LARGE-1:0][BYTE_BITS-1:0] mem;
    logic [BYTE_BITS-1:0]                 rdData;
    logic [PAGE_AW-1:0]                   pageAddr;
    logic [TW-1:0]                        workCnt;
  } sfsp_dev_s;
  sfsp_dev_s st_ff, nxt_st;

  logic                 pushReady;
  logic [PAGE_AW-1:0]   pageLast;
  logic                 csNow;
  logic                 sckNow;
  logic                 siNow;
  logic [BYTE_BITS-1:0] rxByte;
  logic [BYTE_BITS-1:0] txNext;

  // ----------------------------------------
  // receive fifo toward the user
  // ----------------------------------------
  sfsp_fifo #(.W(BYTE_BITS), .D(FIFO_DEPTH)) u_rxFifo (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .inValid  (st_ff.pend),
    .inReady  (pushReady),
    .inData   (st_ff.pendData),
    .outValid (rxValid),
    .outReady (rxReady),
    .outData  (rxData)
  );

  // factory option forces the small page
  assign pageLast = (FACTORY_256 || !cfgPageLarge) ? PAGE_AW'(PAGE_SMALL - 1)
                                                   : PAGE_AW'(PAGE_LARGE - 1);

  assign link.soOut    = st_ff.soOut;
  assign link.soOeN    = st_ff.soOeN;
  assign rxOverrun     = st_ff.overrun;
  assign txTake        = st_ff.txTake;
  assign bufRdData     = st_ff.rdData;
  assign pageAddr      = st_ff.pageAddr;
  assign busy          = (st_ff.workCnt != '0);
  assign standby       = st_ff.csF && !busy;
  assign deepPowerDown = 1'b0;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    nxt_st = st_ff;
    nxt_st.csS  = {st_ff.csS[1:0], link.csN};
    nxt_st.sckS = {st_ff.sckS[1:0], link.sck};
    nxt_st.siS  = {st_ff.siS[1:0], link.si};
    csNow  = sfsp_filt(st_ff.csS, st_ff.csF);
    sckNow = sfsp_filt(st_ff.sckS, st_ff.sckF);
    siNow  = sfsp_filt(st_ff.siS, st_ff.siF);
    nxt_st.csF  = csNow;
    nxt_st.sckF = sckNow;
    nxt_st.siF  = siNow;
    nxt_st.txTake = 1'b0;
    rxByte = {st_ff.rxSh[BYTE_BITS-2:0], siNow};
    txNext = (st_ff.bitCnt == '0) ? txData : {st_ff.txSh[BYTE_BITS-2:0], 1'b0};

    if (st_ff.pend && pushReady) begin
      nxt_st.pend = 1'b0;
    end
    if (clrOverrun) begin
      nxt_st.overrun = 1'b0;
    end

    if (st_ff.csF && !csNow) begin
      // a fresh frame always starts at the first opcode bit
      nxt_st.bitCnt  = '0;
      nxt_st.hdrCnt  = '0;
      nxt_st.bufPtr  = '0;
      nxt_st.sawRise = 1'b0;
      nxt_st.txSh    = txData;
      nxt_st.soOut   = txData[BYTE_BITS-1];
      nxt_st.soOeN   = 1'b0;
      nxt_st.txTake  = 1'b1;
    end else if (csNow) begin
      nxt_st.soOeN = 1'b1;
    end else if (!st_ff.sckF && sckNow) begin
      // only reached while selected, so a deselected line is never shifted in
      nxt_st.rxSh    = rxByte;
      nxt_st.bitCnt  = st_ff.bitCnt + 3'd1;
      nxt_st.sawRise = 1'b1;
      if (st_ff.bitCnt == 3'(BYTE_BITS - 1)) begin
        // user too slow: the older held byte is replaced
        if (st_ff.pend && !pushReady) begin
          nxt_st.overrun = 1'b1;
        end
        nxt_st.pend     = 1'b1;
        nxt_st.pendData = rxByte;
        if (st_ff.hdrCnt < 3'(HDR_BYTES)) begin
          nxt_st.hdrCnt = st_ff.hdrCnt + 3'd1;
          if (st_ff.hdrCnt == 3'd1 || st_ff.hdrCnt == 3'd2) begin
            nxt_st.pageAddr = {st_ff.pageAddr[0], rxByte};
          end
        end else begin
          nxt_st.mem[st_ff.bufPtr] = rxByte;
          nxt_st.bufPtr = (st_ff.bufPtr == pageLast) ? '0 : st_ff.bufPtr + PAGE_AW'(1);
        end
      end
    end else if (st_ff.sckF && !sckNow && st_ff.sawRise) begin
      // a fall before any rise is the mode 3 idle-high lead-in
      nxt_st.txSh   = txNext;
      nxt_st.soOut  = txNext[BYTE_BITS-1];
      nxt_st.txTake = (st_ff.bitCnt == '0);
    end

    nxt_st.rdData = st_ff.mem[bufRdAddr];

    if (workStart) begin
      nxt_st.workCnt = TW'(SELF_TIME);
    end else if (st_ff.workCnt != '0) begin
      nxt_st.workCnt = st_ff.workCnt - TW'(1);
    end
  end

  // ----------------------------------------
  // state register; reset holds everything idle
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
      st_ff.csS   <= '1;
      st_ff.csF   <= 1'b1;
      st_ff.soOeN <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end
endmodule : sfsp_device

`default_nettype wire

/* core/sfsp_pkg.sv */
// shared constants and types for the serial flash front end, both ends
// assumes a single 250 MHz system clock on each end
`default_nettype none

package sfsp_pkg;
  // ----------------------------------------
  // clocking
  // ----------------------------------------
  localparam int SYS_PERIOD_NS  = 4;
  localparam int SYS_MHZ        = 250;
  localparam int SCK_MAX_MHZ    = 66;
  localparam int LINK_PERIOD_NS = 80;
  // least half period that keeps sck at or under its ceiling
  localparam int HALF_MIN       = (SYS_MHZ + 2 * SCK_MAX_MHZ - 1) / (2 * SCK_MAX_MHZ);
  localparam int HALF_CYCLES    = LINK_PERIOD_NS / (2 * SYS_PERIOD_NS);
  localparam int SYNC_STAGES    = 3;

  // ----------------------------------------
  // framing and memory layout
  // ----------------------------------------
  localparam int BYTE_BITS      = 8;
  localparam int HDR_BYTES      = 4;
  localparam int PAGE_SMALL     = 256;
  localparam int PAGE_LARGE     = 264;
  localparam int PAGE_COUNT     = 512;
  localparam int PAGE_AW        = 9;
  localparam int SELF_TIME_NS   = 2000;
  localparam int SELF_CYCLES    = (SELF_TIME_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
  localparam int FIFO_DEPTH     = 4;

  typedef enum logic [1:0] {
    SFSP_MODE0 = 2'b00,
    SFSP_MODE3 = 2'b11
  } sfsp_mode_e;

  typedef enum logic [1:0] {
    SFSP_H_IDLE  = 2'b00,
    SFSP_H_SHIFT = 2'b01,
    SFSP_H_TAIL  = 2'b11,
    SFSP_H_GAP   = 2'b10
  } sfsp_hstate_e;

  // a change on a pin counts once the second and third stages agree
  function automatic logic sfsp_filt(input logic [2:0] s, input logic prev);
    return (s[1] == s[2]) ? s[2] : prev;
  endfunction : sfsp_filt
endpackage : sfsp_pkg

`default_nettype wire

/* core/sfsp_link_if.sv */
// four-wire link between host end and device end
// the output line is modelled as pulled high while the device does not drive it
`default_nettype none

interface sfsp_link_if;
  logic csN;
  logic sck;
  logic si;
  logic soOut;
  logic soOeN;
  logic soLevel;

  assign soLevel = soOeN ? 1'b1 : soOut;

  modport dev  (input csN, input sck, input si, output soOut, output soOeN);
  modport host (output csN, output sck, output si, input soLevel);
endinterface : sfsp_link_if

`default_nettype wire

/* core/sfsp_host.sv */
// host end of the serial flash link: makes sck by division, frames bytes
// assumes the user feeds bytes with a last marker; the link output is sampled as a pin
`default_nettype none

module sfsp_host
  import sfsp_pkg::*;
#(
  parameter sfsp_mode_e MODE = SFSP_MODE0,
  parameter int         HALF = HALF_CYCLES
) (
  // clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 rst_n,
  // link
  sfsp_link_if.host                 link,
  // bytes to send
  input  wire logic                 cmdValid,
  output logic                      cmdReady,
  input  wire logic [BYTE_BITS-1:0] cmdData,
  input  wire logic                 cmdLast,
  // bytes received
  output logic                      rspValid,
  output logic [BYTE_BITS-1:0]      rspData,
  output logic                      active
);
  // never faster than the ceiling, whatever the parameter says
  localparam int HALF_USE = (HALF < HALF_MIN) ? HALF_MIN : HALF;
  localparam int DW       = $clog2(HALF_USE + 1);
  localparam logic IDLE_SCK = MODE[0];
  typedef struct packed {
    sfsp_hstate_e           st;
    logic [DW-1:0]          div;
    logic                   csN;
    logic                   sck;
    logic                   si;
    logic [BYTE_BITS-1:0]   sh;
    logic [BYTE_BITS-1:0]   rx;
    logic [2:0]             bitCnt;
    logic                   full;
    logic                   last;
    logic                   skipFall;
    logic [SYNC_STAGES-1:0] soS;
    logic                   soF;
    logic                   rspValid;
    logic [BYTE_BITS-1:0]   rspData;
  } sfsp_host_s;
  sfsp_host_s st_ff, nxt_st;

  logic tick;
  logic soNow;
  logic [BYTE_BITS-1:0] rxByte;

  assign tick     = (st_ff.div == DW'(HALF_USE - 1));
  assign cmdReady = (st_ff.st == SFSP_H_IDLE) ||
                    (st_ff.st == SFSP_H_SHIFT && tick && st_ff.sck && st_ff.full && !st_ff.last);
  assign link.csN = st_ff.csN;
  assign link.sck = st_ff.sck;
  assign link.si  = st_ff.si;
  assign rspValid = st_ff.rspValid;
  assign rspData  = st_ff.rspData;
  assign active   = !st_ff.csN;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    nxt_st = st_ff;
    nxt_st.soS = {st_ff.soS[1:0], link.soLevel};
    soNow = sfsp_filt(st_ff.soS, st_ff.soF);
    nxt_st.soF = soNow;
    nxt_st.rspValid = 1'b0;
    rxByte = {st_ff.rx[BYTE_BITS-2:0], soNow};
    nxt_st.div = tick ? '0 : st_ff.div + DW'(1);

    unique case (st_ff.st)
      SFSP_H_IDLE: begin
        nxt_st.div = '0;
        nxt_st.sck = IDLE_SCK;
        if (cmdValid) begin
          nxt_st.st       = SFSP_H_SHIFT;
          nxt_st.csN      = 1'b0;
          nxt_st.sh       = cmdData;
          nxt_st.si       = cmdData[BYTE_BITS-1];
          nxt_st.last     = cmdLast;
          nxt_st.bitCnt   = '0;
          nxt_st.full     = 1'b0;
          nxt_st.skipFall = IDLE_SCK;
        end
      end
      SFSP_H_SHIFT: begin
        if (tick && !st_ff.sck) begin
          nxt_st.sck    = 1'b1;
          nxt_st.rx     = rxByte;
          nxt_st.bitCnt = st_ff.bitCnt + 3'd1;
          if (st_ff.bitCnt == 3'(BYTE_BITS - 1)) begin
            nxt_st.full     = 1'b1;
            nxt_st.rspValid = 1'b1;
            nxt_st.rspData  = rxByte;
            if (st_ff.last && IDLE_SCK) begin
              nxt_st.st = SFSP_H_TAIL;
            end
          end
        end else if (tick && st_ff.sck) begin
          if (st_ff.skipFall) begin
            nxt_st.sck      = 1'b0;
            nxt_st.skipFall = 1'b0;
          end else if (!st_ff.full) begin
            nxt_st.sck = 1'b0;
            nxt_st.sh  = {st_ff.sh[BYTE_BITS-2:0], 1'b0};
            nxt_st.si  = st_ff.sh[BYTE_BITS-2];
          end else if (st_ff.last) begin
            nxt_st.sck = 1'b0;
            nxt_st.st  = SFSP_H_TAIL;
          end else if (cmdValid) begin
            nxt_st.sck  = 1'b0;
            nxt_st.full = 1'b0;
            nxt_st.sh   = cmdData;
            nxt_st.si   = cmdData[BYTE_BITS-1];
            nxt_st.last = cmdLast;
          end else begin
            // no byte yet: park with sck high, which both modes tolerate
            nxt_st.div = st_ff.div;
          end
        end
      end
      SFSP_H_TAIL: begin
        if (tick) begin
          nxt_st.csN = 1'b1;
          nxt_st.st  = SFSP_H_GAP;
        end
      end
      SFSP_H_GAP: begin
        nxt_st.sck = IDLE_SCK;
        if (tick) begin
          nxt_st.st = SFSP_H_IDLE;
        end
      end
    endcase
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff     <= '0;
      st_ff.st  <= SFSP_H_IDLE;
      st_ff.csN <= 1'b1;
      st_ff.sck <= IDLE_SCK;
      st_ff.soS <= '1;
      st_ff.soF <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end
endmodule : sfsp_host

`default_nettype wire

/* verification/sfsp_link_sva.sv */
// assertions on the link wires between the host end and the device end
// assumes a mode 0 host whose sck halves last at least nine system cycles
`default_nettype none

module sfsp_link_sva (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // link wires
  input wire logic csN,
  input wire logic sck,
  input wire logic si,
  input wire logic soOut,
  input wire logic soOeN
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [2:0] riseCnt_ff;
  logic       sckQ_ff;

  // ------------------------------
  // sck rises in the frame, mod 8
  // ------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      riseCnt_ff <= 3'h0;
      sckQ_ff    <= 1'b0;
    end else begin
      sckQ_ff    <= sck;
      riseCnt_ff <= csN ? 3'h0 : riseCnt_ff + 3'(sck & ~sckQ_ff);
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  chk_oe_released: assert property (csN [*6] |-> soOeN)
    else $error("output driven while deselected");
  chk_oe_driven: assert property ($fell(csN) |-> ##[2:6] !soOeN)
    else $error("output not driven after select");
  chk_idle_clock: assert property (csN |-> !sck)
    else $error("clock not at idle level");
  chk_high_half: assert property ($rose(sck) |=> $stable(sck) [*8])
    else $error("clock high half too short");
  chk_low_half: assert property ($fell(sck) |=> !sck [*8])
    else $error("clock low half too short");
  chk_si_settled: assert property ($rose(sck) |-> si == $past(si, 4))
    else $error("input moved before the rise");
  chk_out_on_fall: assert property ($changed(soOut) |-> !sck)
    else $error("output moved while clock high");
  chk_whole_bytes: assert property ($rose(csN) |-> riseCnt_ff == 3'h0)
    else $error("frame ended mid byte");
  chk_select_gap: assert property ($rose(csN) |=> csN [*8])
    else $error("deselect gap too short");
  chk_first_rise: assert property ($fell(csN) |-> !sck [*8])
    else $error("clock rose too soon after select");
endmodule : sfsp_link_sva

`default_nettype wire

/* verification/sfsp_tb.sv */
// bench: a mode 0 host and a mode 3 host, each joined to a device by its own link, a further device driven by hand
// assumes the package, interface, fifo and both ends are compiled first
`default_nettype none

module sfsp_tb
  import sfsp_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;

  // shortened self time so a frame ends while work runs
  localparam int SELF_SIM = 300;

  logic sys_clk = 1'b0, rst_n = 1'b0;
  logic cmdValid = 1'b0, cmdLast = 1'b0, cmdReady, rspValid, active;
  logic [7:0] cmdData = 8'h00, rspData, rxData, rxDataB, txData = 8'h00, bufRdData;
  logic cfgPageLarge = 1'b0, rxReady = 1'b1, clrOverrun = 1'b0, workStart = 1'b0;
  logic rxValid, rxValidB, rxOverrun, txTake, busy, standby, deepPowerDown;
  logic [8:0] bufRdAddr = 9'h000, pageAddr;
  logic m3Sel = 1'b0, cmdReadyA, cmdReadyC, activeC, rspValidC, txTakeC;
  logic [7:0] rspDataC;
  logic [8:0] pageAddrC;
  logic [7:0] frm [0:299];
  logic [7:0] devQ [$];
  logic [7:0] rspQ [$];
  int bad_count = 0, cmp_count = 0, cyc = 0, txIdx = 0;

  sfsp_link_if link ();
  sfsp_link_if linkB ();
  sfsp_link_if linkC ();

  sfsp_host #(.MODE(SFSP_MODE0), .HALF(HALF_CYCLES)) u_sfsp_host (
    .sys_clk(sys_clk), .rst_n(rst_n), .link(link), .cmdValid(cmdValid & ~m3Sel), .cmdReady(cmdReadyA),
    .cmdData(cmdData), .cmdLast(cmdLast), .rspValid(rspValid), .rspData(rspData), .active(active));
  sfsp_device #(.FACTORY_256(1'b0), .SELF_TIME(SELF_SIM)) u_sfsp_device (
    .sys_clk(sys_clk), .rst_n(rst_n), .link(link), .cfgPageLarge(cfgPageLarge),
    .rxValid(rxValid), .rxReady(rxReady), .rxData(rxData), .rxOverrun(rxOverrun),
    .clrOverrun(clrOverrun), .txData(txData), .txTake(txTake), .bufRdAddr(bufRdAddr),
    .bufRdData(bufRdData), .pageAddr(pageAddr), .workStart(workStart), .busy(busy),
    .standby(standby), .deepPowerDown(deepPowerDown));
  sfsp_device #(.FACTORY_256(1'b0), .SELF_TIME(SELF_SIM)) u_sfsp_device_b (
    .sys_clk(sys_clk), .rst_n(rst_n), .link(linkB), .cfgPageLarge(cfgPageLarge),
    .rxValid(rxValidB), .rxReady(rxReady), .rxData(rxDataB), .rxOverrun(),
    .clrOverrun(clrOverrun), .txData(txData), .txTake(), .bufRdAddr(bufRdAddr),
    .bufRdData(), .pageAddr(), .workStart(workStart), .busy(), .standby(), .deepPowerDown());
  sfsp_host #(.MODE(SFSP_MODE3), .HALF(HALF_CYCLES)) u_sfsp_host_c (
    .sys_clk(sys_clk), .rst_n(rst_n), .link(linkC), .cmdValid(cmdValid & m3Sel), .cmdReady(cmdReadyC),
    .cmdData(cmdData), .cmdLast(cmdLast), .rspValid(rspValidC), .rspData(rspDataC), .active(activeC));
  sfsp_device #(.FACTORY_256(1'b0), .SELF_TIME(SELF_SIM)) u_sfsp_device_c (
    .sys_clk(sys_clk), .rst_n(rst_n), .link(linkC), .cfgPageLarge(cfgPageLarge),
    .rxValid(), .rxReady(rxReady), .rxData(), .rxOverrun(),
    .clrOverrun(clrOverrun), .txData(txData), .txTake(txTakeC), .bufRdAddr(bufRdAddr),
    .bufRdData(), .pageAddr(pageAddrC), .workStart(workStart), .busy(), .standby(), .deepPowerDown());
  // one host at a time owns the shared command stream
  assign cmdReady = m3Sel ? cmdReadyC : cmdReadyA;
  sfsp_link_sva u_sfsp_link_sva (.sys_clk(sys_clk), .rst_n(rst_n), .csN(link.csN),
    .sck(link.sck), .si(link.si), .soOut(link.soOut), .soOeN(link.soOeN));

  always #2 sys_clk = ~sys_clk;

  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (rspValid === 1'b1) rspQ.push_back(rspData);
    if (rspValidC === 1'b1) rspQ.push_back(rspDataC);
    if (rxValid === 1'b1 && rxReady === 1'b1) devQ.push_back(rxData);
  end

  // next reply byte once the device has taken the current one
  always @(negedge sys_clk) begin
    if (txTake === 1'b1 || txTakeC === 1'b1) begin
      txIdx++;
      txData = 8'(txIdx) ^ 8'hC0;
    end
  end

  // ------------------------------
  // shared tasks
  // ------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t %s", $time, what);
    end
  endtask : check

  task automatic print_verdict();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : print_verdict

  task automatic hang(input int n);
    if (n > 1000) begin
      check(16'h0000, 16'h0001, "wait ran out");
      print_verdict();
    end
  endtask : hang

  task automatic waitc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : waitc

  task automatic send_frame(input int len);
    int n;
    for (int i = 0; i < len; i++) begin
      @(negedge sys_clk);
      cmdValid = 1'b1;
      cmdData = frm[i];
      cmdLast = (i == len - 1);
      for (n = 0; cmdReady !== 1'b1; n++) begin
        hang(n);
        @(negedge sys_clk);
      end
      @(posedge sys_clk);
    end
    @(negedge sys_clk);
    cmdValid = 1'b0;
    for (n = 0; (active | activeC) !== 1'b0 || cmdReady !== 1'b1; n++) begin
      hang(n);
      @(negedge sys_clk);
    end
    waitc(12);
  endtask : send_frame

  task automatic fill(input int len, input logic [7:0] seed);
    for (int i = 0; i < len; i++) frm[i] = seed + 8'(i * 37);
  endtask : fill

  task automatic rd_buf(input logic [8:0] a, input logic [7:0] exp);
    @(negedge sys_clk);
    bufRdAddr = a;
    waitc(1);
    check(16'(bufRdData), 16'(exp), "buffer byte");
  endtask : rd_buf

  task automatic b_bit(input logic v);
    linkB.sck = 1'b0;
    linkB.si = v;
    waitc(10);
    linkB.sck = 1'b1;
    waitc(10);
  endtask : b_bit

  // ------------------------------
  // scenarios
  // ------------------------------
  task automatic test_frame();
    fill(6, 8'hA5);
    frm[1] = 8'h01;
    frm[2] = 8'h2C;
    rspQ.delete();
    txIdx = 0;
    txData = 8'hC0;
    send_frame(6);
    check(16'(devQ.size()), 16'h0006, "rx count");
    for (int i = 0; i < 6; i++) check(16'(devQ[i]), 16'(frm[i]), "rx byte");
    for (int i = 0; i < 6; i++) check(16'(rspQ[i]), 16'(8'(i) ^ 8'hC0), "reply byte");
    check(16'(pageAddr), 16'h012C, "page address");
    rd_buf(9'h000, frm[4]);
    rd_buf(9'h001, frm[5]);
  endtask : test_frame

  task automatic test_overrun();
    rxReady = 1'b0;
    devQ.delete();
    fill(7, 8'h11);
    send_frame(7);
    check(16'(rxOverrun), 16'h0001, "overrun set");
    rxReady = 1'b1;
    waitc(12);
    check(16'(devQ.size()), 16'h0005, "fifo depth plus held byte");
    for (int i = 0; i < 4; i++) check(16'(devQ[i]), 16'(frm[i]), "fifo order");
    check(16'(devQ[4]), 16'(frm[6]), "newest byte kept");
    check(16'(rxValid), 16'h0000, "fifo empty");
    clrOverrun = 1'b1;
    waitc(1);
    clrOverrun = 1'b0;
    waitc(1);
    check(16'(rxOverrun), 16'h0000, "overrun clear");
    rd_buf(9'h000, frm[4]);
  endtask : test_overrun

  task automatic test_wrap();
    cfgPageLarge = 1'b1;
    devQ.delete();
    fill(269, 8'h07);
    frm[1] = 8'hFF;
    frm[2] = 8'hFF;
    send_frame(269);
    check(16'(devQ.size()), 16'h010D, "long frame count");
    check(16'(pageAddr), 16'h01FF, "top page");
    rd_buf(9'h107, frm[267]);
    rd_buf(9'h000, frm[268]);
    cfgPageLarge = 1'b0;
  endtask : test_wrap

  task automatic test_work();
    int t0;
    check(16'(standby), 16'h0001, "standby when idle");
    check(16'(deepPowerDown), 16'h0000, "no deep sleep");
    workStart = 1'b1;
    waitc(1);
    workStart = 1'b0;
    t0 = cyc;
    fill(1, 8'h9B);
    send_frame(1);
    check(16'(busy), 16'h0001, "busy after frame");
    check(16'(standby), 16'h0000, "standby held off");
    for (int n = 0; busy !== 1'b0; n++) begin
      hang(n);
      waitc(1);
    end
    check(16'(cyc - t0 > SELF_SIM - 3 && cyc - t0 < SELF_SIM + 3), 16'h0001, "self time");
    check(16'(standby), 16'h0001, "standby after work");
  endtask : test_work

  // mode 3 by hand: idle-high clock, noise while deselected, a cut-off byte
  task automatic test_link_b();
    logic [7:0] v;
    v = 8'h96;
    rxReady = 1'b0;
    for (int i = 0; i < 16; i++) b_bit(i[0]);
    check(16'(rxValidB), 16'h0000, "taken while deselected");
    check(16'(linkB.soOeN), 16'h0001, "driven while deselected");
    linkB.csN = 1'b0;
    waitc(10);
    for (int i = 0; i < 3; i++) b_bit(1'b1);
    linkB.csN = 1'b1;
    waitc(10);
    linkB.csN = 1'b0;
    waitc(10);
    check(16'(linkB.soOeN), 16'h0000, "released while selected");
    for (int i = 7; i >= 0; i--) b_bit(v[i]);
    waitc(10);
    check(16'(rxValidB), 16'h0001, "mode 3 byte");
    check(16'(rxDataB), 16'(v), "mode 3 value");
    linkB.csN = 1'b1;
    waitc(10);
    check(16'(linkB.soOeN), 16'h0001, "released at end");
    rxReady = 1'b1;
  endtask : test_link_b

  // mode 3 host against its own device: idle-high clock, lead-in fall skipped
  task automatic test_mode3();
    m3Sel = 1'b1;
    fill(6, 8'h3D);
    frm[1] = 8'h01;
    frm[2] = 8'h77;
    rspQ.delete();
    txIdx = 0;
    txData = 8'hC0;
    send_frame(6);
    check(16'(linkC.sck), 16'h0001, "mode 3 idle level");
    check(16'(rspQ.size()), 16'h0006, "mode 3 reply count");
    for (int i = 0; i < 6; i++) check(16'(rspQ[i]), 16'(8'(i) ^ 8'hC0), "mode 3 reply");
    check(16'(pageAddrC), 16'h0177, "mode 3 address");
    m3Sel = 1'b0;
  endtask : test_mode3

  initial begin
    linkB.csN = 1'b1;
    linkB.sck = 1'b1;
    linkB.si = 1'b0;
    waitc(12);
    rst_n = 1'b1;
    waitc(2);
    test_frame();
    test_overrun();
    test_wrap();
    test_work();
    test_link_b();
    test_mode3();
    print_verdict();
  end
endmodule : sfsp_tb

`default_nettype wire
